/* rtl/dfr_decode.v */
/*
 * decodes one reaction code into a ramp choice and a final state.
 * assumes the caller registers the outputs; pure combinational.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dfr_defines.vh"

module dfr_decode
(
    // code in
    input wire [15:0] code,
    input wire is_limit,
    // action out
    output reg [1:0] ramp,
    output reg [1:0] fin
);

always @*
begin
    ramp = `DFR_RAMP_NONE;
    fin = `DFR_END_KEEP;
    if (!is_limit)
    begin
        case (code)
            `DFR_CODE_FREE:
            begin
                ramp = `DFR_RAMP_FREE;
                fin = `DFR_END_DISABLED;
            end
            `DFR_CODE_SLOW: ramp = `DFR_RAMP_SLOW;
            `DFR_CODE_QUICK: ramp = `DFR_RAMP_QUICK;
            default: ramp = `DFR_RAMP_NONE;
        endcase
    end
    else
    begin
        case (code)
            `DFR_CODE_SLOW:
            begin
                ramp = `DFR_RAMP_SLOW;
                fin = `DFR_END_DISABLED;
            end
            `DFR_CODE_QUICK:
            begin
                ramp = `DFR_RAMP_QUICK;
                fin = `DFR_END_DISABLED;
            end
            `DFR_CODE_SLOW_QSA:
            begin
                ramp = `DFR_RAMP_SLOW;
                fin = `DFR_END_QSA;
            end
            `DFR_CODE_QUICK_QSA:
            begin
                ramp = `DFR_RAMP_QUICK;
                fin = `DFR_END_QSA;
            end
            default: ramp = `DFR_RAMP_NONE;
        endcase
    end
end

endmodule // dfr_decode
`default_nettype wire

/* rtl/dfr_defines.vh */
/*
 * constants for the drive fault reaction select block: object offsets,
 * reset values, reaction codes and bit positions.
 * assumes it is included by bare name from files under rtl/.
 */
// What this block does
// - apply deviation reaction on following/slippage error
// - code 0 disables drive, motor turns freely
// - code 1 brakes with slow-down ramp
// - code 2 brakes with quick-stop ramp
// - limit passed sets warning bit 7, then reacts
// - limit code -1 means no reaction
// - codes 1/2 brake then switch-on-disabled
// - codes 5/6 brake then quick-stop-active, energized
// - quick-stop control bit not cleared on entry
// - read-only eeprom size, zero when absent
// - reserved 32-bit config word resets to zero
`ifndef DFR_DEFINES_VH
`define DFR_DEFINES_VH

// ********************************************************
// object offsets
// ********************************************************
`define DFR_OFS_DEV_REACT 16'h3700
`define DFR_OFS_LIM_REACT 16'h3701
`define DFR_OFS_EE_SIZE 16'h4012
`define DFR_OFS_HW_CFG 16'h4013

// ********************************************************
// reset values
// ********************************************************
`define DFR_RST_REACT 16'hFFFF
`define DFR_RST_WORD 32'h0000_0000

// ********************************************************
// reaction codes
// ********************************************************
`define DFR_CODE_NONE 16'hFFFF
`define DFR_CODE_FREE 16'h0000
`define DFR_CODE_SLOW 16'h0001
`define DFR_CODE_QUICK 16'h0002
`define DFR_CODE_SLOW_QSA 16'h0005
`define DFR_CODE_QUICK_QSA 16'h0006

// ********************************************************
// status and control bits
// ********************************************************
`define DFR_SW_WARN_BIT 7
`define DFR_CW_QS_BIT 2
// reaction words are 16 bit signed and widen by sign copy on read
`define DFR_SIGN_BIT 15
`define DFR_EXT_BITS 16

// ********************************************************
// action encoding {ramp(2), final state(2)}
// ********************************************************
`define DFR_RAMP_NONE 2'h0
`define DFR_RAMP_FREE 2'h1
`define DFR_RAMP_SLOW 2'h2
`define DFR_RAMP_QUICK 2'h3
`define DFR_END_KEEP 2'h0
`define DFR_END_DISABLED 2'h1
`define DFR_END_QSA 2'h2

`endif

/* rtl/dfr_qs_track.v */
/*
 * tracks the quick-stop control bit: a 0 then 1 sequence from the host
 * arms a return to operation enabled.
 * assumes cw_write pulses one cycle with the written control word.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dfr_defines.vh"

module dfr_qs_track
(
    // clock and reset
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    // control word
    input wire cw_write,
    input wire [15:0] cw_data,
    input wire in_qsa,
    // result
    output reg qs_bit_reg,
    output reg resume_reg
);

reg seen_zero_reg;

// bit is only stored from host writes, never cleared by state entry
always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        qs_bit_reg <= 1'b0;
        seen_zero_reg <= 1'b0;
        resume_reg <= 1'b0;
    end
    else if (clk_en)
    begin
        resume_reg <= 1'b0;
        if (!in_qsa)
            seen_zero_reg <= 1'b0;
        if (cw_write)
        begin
            qs_bit_reg <= cw_data[`DFR_CW_QS_BIT];
            if (in_qsa && !cw_data[`DFR_CW_QS_BIT])
                seen_zero_reg <= 1'b1;
            if (in_qsa && seen_zero_reg && cw_data[`DFR_CW_QS_BIT])
            begin
                resume_reg <= 1'b1;
                seen_zero_reg <= 1'b0;
            end
        end
    end
end

endmodule // dfr_qs_track
`default_nettype wire

/* rtl/dfr_top.v */
/*
 * drive fault reaction select: object store for the two reaction codes,
 * eeprom size and hardware config, plus the reaction sequencer.
 * assumes a fieldbus object port (index, write strobe, read strobe)
 * synchronous to sys_clk; the ramp generator reports ramp_done.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dfr_defines.vh"

module dfr_top
(
    // clock and reset
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    // object access
    input wire obj_wr,
    input wire obj_rd,
    input wire [15:0] obj_index,
    input wire [31:0] obj_wdata,
    output reg [31:0] obj_rdata_reg,
    output reg obj_ack_reg,
    output reg obj_err_reg,
    // control word from host
    input wire cw_write,
    input wire [15:0] cw_data,
    // hardware facts and events
    input wire [31:0] eeprom_bytes,
    input wire deviation_err,
    input wire limit_passed,
    input wire ramp_done,
    input wire warn_clear,
    // drive commands
    output reg drive_disable_reg,
    output reg [1:0] ramp_sel_reg,
    output reg go_switch_on_disabled_reg,
    output reg go_quick_stop_active_reg,
    output reg go_operation_enabled_reg,
    output reg energized_reg,
    output reg status_warn_reg,
    output reg qs_bit_out_reg,
    output reg [31:0] hw_cfg_out_reg
);

// ********************************************************
// state
// ********************************************************
localparam ST_RUN = 2'h0;
localparam ST_BRAKE = 2'h1;
localparam ST_QSA = 2'h2;
localparam ST_OFF = 2'h3;

reg [15:0] dev_code_reg;
reg [15:0] lim_code_reg;
reg [31:0] hw_cfg_reg;
reg [31:0] rdata_next;
reg rd_err_next;
reg [1:0] state_reg;
reg [1:0] state_next;
reg [1:0] fin_reg;
wire [1:0] dev_ramp;
wire [1:0] dev_fin;
wire [1:0] lim_ramp;
wire [1:0] lim_fin;
wire qs_bit;
wire resume;
wire take_dev;
wire take_lim;

// ********************************************************
// decoders and quick-stop tracker
// ********************************************************
dfr_decode u_dev
(
    .code(dev_code_reg),
    .is_limit(1'b0),
    .ramp(dev_ramp),
    .fin(dev_fin)
);

dfr_decode u_lim
(
    .code(lim_code_reg),
    .is_limit(1'b1),
    .ramp(lim_ramp),
    .fin(lim_fin)
);

dfr_qs_track u_qs
(
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .cw_write(cw_write),
    .cw_data(cw_data),
    .in_qsa(state_reg == ST_QSA),
    .qs_bit_reg(qs_bit),
    .resume_reg(resume)
);

// ********************************************************
// event qualification
// ********************************************************
// deviation wins, but a reserved deviation code must not mask a valid limit reaction
assign take_dev = deviation_err && (dev_ramp != `DFR_RAMP_NONE);
assign take_lim = limit_passed && (lim_ramp != `DFR_RAMP_NONE) && !take_dev;

// ********************************************************
// object store
// ********************************************************
// reaction words are 16 bit signed; upper bits of writes are dropped
always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        dev_code_reg <= `DFR_RST_REACT;
        lim_code_reg <= `DFR_RST_REACT;
        hw_cfg_reg <= `DFR_RST_WORD;
        obj_rdata_reg <= `DFR_RST_WORD;
        obj_ack_reg <= 1'b0;
        obj_err_reg <= 1'b0;
    end
    else if (clk_en)
    begin
        obj_ack_reg <= obj_wr | obj_rd;
        obj_err_reg <= 1'b0;
        obj_rdata_reg <= `DFR_RST_WORD;
        if (obj_wr)
        begin
            case (obj_index)
                `DFR_OFS_DEV_REACT: dev_code_reg <= obj_wdata[`DFR_SIGN_BIT:0];
                `DFR_OFS_LIM_REACT: lim_code_reg <= obj_wdata[`DFR_SIGN_BIT:0];
                `DFR_OFS_HW_CFG: hw_cfg_reg <= obj_wdata;
                // eeprom size refuses writes
                default: obj_err_reg <= 1'b1;
            endcase
        end
        else if (obj_rd)
        begin
            obj_rdata_reg <= rdata_next;
            obj_err_reg <= rd_err_next;
        end
    end
end

// ********************************************************
// read selection
// ********************************************************
// eeprom size is read straight from the pins so a read shows the size of that cycle
always @*
begin
    rdata_next = `DFR_RST_WORD;
    rd_err_next = 1'b0;
    case (obj_index)
        `DFR_OFS_DEV_REACT:
        begin
            rdata_next = {{`DFR_EXT_BITS{dev_code_reg[`DFR_SIGN_BIT]}}, dev_code_reg};
        end
        `DFR_OFS_LIM_REACT:
        begin
            rdata_next = {{`DFR_EXT_BITS{lim_code_reg[`DFR_SIGN_BIT]}}, lim_code_reg};
        end
        `DFR_OFS_EE_SIZE:
        begin
            rdata_next = eeprom_bytes;
        end
        `DFR_OFS_HW_CFG:
        begin
            rdata_next = hw_cfg_reg;
        end
        default:
        begin
            rd_err_next = 1'b1;
        end
    endcase
end

// ********************************************************
// reaction sequencer
// ********************************************************
always @*
begin
    state_next = state_reg;
    case (state_reg)
        ST_RUN:
        begin
            if (take_dev)
                state_next = (dev_ramp == `DFR_RAMP_FREE) ? ST_OFF : ST_BRAKE;
            else if (take_lim)
                state_next = ST_BRAKE;
        end
        ST_BRAKE:
        begin
            if (ramp_done)
            begin
                case (fin_reg)
                    `DFR_END_DISABLED: state_next = ST_OFF;
                    `DFR_END_QSA: state_next = ST_QSA;
                    default: state_next = ST_RUN;
                endcase
            end
        end
        ST_QSA:
        begin
            // leaving needs the host's 0 then 1 on the quick-stop bit
            if (resume)
                state_next = ST_RUN;
        end
        ST_OFF:
        begin
            state_next = ST_OFF;
        end
        default: state_next = ST_RUN;
    endcase
end

// ********************************************************
// sequencer registers and drive commands
// ********************************************************
// switch-on-disabled is left only by reset; the outer state machine owns it
always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        state_reg <= ST_RUN;
        fin_reg <= `DFR_END_KEEP;
        ramp_sel_reg <= `DFR_RAMP_NONE;
        drive_disable_reg <= 1'b0;
        go_switch_on_disabled_reg <= 1'b0;
        go_quick_stop_active_reg <= 1'b0;
        go_operation_enabled_reg <= 1'b0;
        energized_reg <= 1'b1;
    end
    else if (clk_en)
    begin
        state_reg <= state_next;
        go_switch_on_disabled_reg <= 1'b0;
        go_quick_stop_active_reg <= 1'b0;
        go_operation_enabled_reg <= resume && (state_reg == ST_QSA);
        if (state_reg == ST_RUN && state_next == ST_OFF)
        begin
            ramp_sel_reg <= `DFR_RAMP_FREE;
            drive_disable_reg <= 1'b1;
            energized_reg <= 1'b0;
            go_switch_on_disabled_reg <= 1'b1;
        end
        else if (state_reg == ST_RUN && state_next == ST_BRAKE)
        begin
            if (take_dev)
            begin
                ramp_sel_reg <= dev_ramp;
                fin_reg <= dev_fin;
            end
            else
            begin
                ramp_sel_reg <= lim_ramp;
                fin_reg <= lim_fin;
            end
        end
        else if (state_reg == ST_BRAKE && state_next != ST_BRAKE)
        begin
            ramp_sel_reg <= `DFR_RAMP_NONE;
            if (state_next == ST_OFF)
            begin
                drive_disable_reg <= 1'b1;
                energized_reg <= 1'b0;
                go_switch_on_disabled_reg <= 1'b1;
            end
            else if (state_next == ST_QSA)
            begin
                go_quick_stop_active_reg <= 1'b1;
            end
        end
    end
end

// ********************************************************
// warning flag
// ********************************************************
// an event in the clearing cycle keeps the flag; set wins over clear
always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        status_warn_reg <= 1'b0;
    end
    else if (clk_en)
    begin
        if (limit_passed)
        begin
            status_warn_reg <= 1'b1;
        end
        else if (warn_clear)
        begin
            status_warn_reg <= 1'b0;
        end
    end
end

// ********************************************************
// output copies
// ********************************************************
// qs bit is only mirrored here; no state entry writes it
always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        qs_bit_out_reg <= 1'b0;
        hw_cfg_out_reg <= `DFR_RST_WORD;
    end
    else if (clk_en)
    begin
        qs_bit_out_reg <= qs_bit;
        hw_cfg_out_reg <= hw_cfg_reg;
    end
end

endmodule // dfr_top
`default_nettype wire

/* tb/dfr_host.sv */
/*
 * fieldbus host model: object accesses and control word writes.
 * assumes inputs change 1 ns after the clock edge.
 */
`timescale 1ns/10ps
`default_nettype none

// ****************
// host model
// ****************
module dfr_host (
    // answers
    input wire logic sys_clk,
    input wire logic [31:0] obj_rdata_reg,
    input wire logic obj_ack_reg,
    input wire logic obj_err_reg,
    // requests
    output var logic obj_wr,
    output var logic obj_rd,
    output var logic [15:0] obj_index,
    output var logic [31:0] obj_wdata,
    output var logic cw_write,
    output var logic [15:0] cw_data
);
    initial
    begin
        {obj_wr, obj_rd, cw_write} = 3'h0;
        {obj_index, obj_wdata, cw_data} = 64'h0;
    end

    // released lines show the inverse so stale data never looks valid
    task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d,
        output logic [31:0] q, output logic [1:0] ae);
        @(posedge sys_clk);
        #1;
        {obj_wr, obj_rd, obj_index, obj_wdata} = {w, !w, i, d};
        @(posedge sys_clk);
        #1;
        q = obj_rdata_reg;
        ae = {obj_ack_reg, obj_err_reg};
        {obj_wr, obj_rd, obj_index, obj_wdata} = {2'h0, ~i, ~d};
    endtask

    task automatic cw(input logic [15:0] d);
        @(posedge sys_clk);
        #1;
        {cw_write, cw_data} = {1'b1, d};
        @(posedge sys_clk);
        #1;
        {cw_write, cw_data} = {1'b0, ~d};
    endtask

    // quick-stop bit low then high again to leave quick stop
    task automatic resume;
        cw(16'h0000);
        cw(16'h0004);
    endtask
endmodule // dfr_host
`default_nettype wire

/* tb/dfr_properties.sv */
/*
 * checker for dfr_top: port-level relations of the fault reaction block.
 * assumes it is bound to dfr_top with all watched ports by name.
 */
`timescale 1ns/10ps
`default_nettype none

// ****************
// checker
// ****************
module dfr_properties (
    // watched ports
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic obj_wr,
    input wire logic obj_rd,
    input wire logic [15:0] obj_index,
    input wire logic obj_ack_reg,
    input wire logic obj_err_reg,
    input wire logic [31:0] obj_rdata_reg,
    input wire logic [31:0] eeprom_bytes,
    input wire logic cw_write,
    input wire logic [15:0] cw_data,
    input wire logic ramp_done,
    input wire logic limit_passed,
    input wire logic drive_disable_reg,
    input wire logic [1:0] ramp_sel_reg,
    input wire logic go_switch_on_disabled_reg,
    input wire logic go_quick_stop_active_reg,
    input wire logic go_operation_enabled_reg,
    input wire logic energized_reg,
    input wire logic status_warn_reg,
    input wire logic qs_bit_out_reg
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_req_acked: assert property ((obj_wr || obj_rd) && clk_en |=> obj_ack_reg)
        else $error("access not acknowledged");
    a_ee_ro_err: assert property (obj_wr && clk_en && obj_index == 16'h4012 |=> obj_err_reg)
        else $error("size word write not refused");
    a_ee_read_val: assert property (obj_rd && !obj_wr && clk_en && obj_index == 16'h4012
        |=> obj_rdata_reg == $past(eeprom_bytes))
        else $error("size word read wrong");
    a_dis_sticks: assert property (drive_disable_reg |=> drive_disable_reg)
        else $error("disable dropped");
    a_free_blocks: assert property (ramp_sel_reg == 2'h1 |-> drive_disable_reg)
        else $error("free wheel without disable");
    a_ramp_holds: assert property (ramp_sel_reg != 2'h0 && !ramp_done |=> $stable(ramp_sel_reg))
        else $error("ramp choice changed early");
    a_warn_cause: assert property ($rose(status_warn_reg) |-> $past(limit_passed))
        else $error("warning without limit event");
    a_qsa_energized: assert property (go_quick_stop_active_reg |-> energized_reg)
        else $error("quick stop entry de-energized");
    a_qs_untouched: assert property (qs_bit_out_reg != $past(qs_bit_out_reg) |-> $past(cw_write, 2))
        else $error("quick stop bit moved alone");
    a_resume_cause: assert property (go_operation_enabled_reg
        |-> $past(cw_write, 2) && $past(cw_data[2], 2))
        else $error("resume without bit set");
    a_sod_cause: assert property (go_switch_on_disabled_reg
        |-> $past(ramp_done) || ramp_sel_reg == 2'h1)
        else $error("disabled entry without cause");

    c_free: cover property (ramp_sel_reg == 2'h1);
    c_qsa: cover property (go_quick_stop_active_reg);
    c_resume: cover property (go_operation_enabled_reg);
endmodule // dfr_properties

bind dfr_top dfr_properties u_props (.*);
`default_nettype wire

/* tb/tb_top.sv */
/*
 * testbench for dfr_top: object store, reactions, quick-stop handshake.
 * assumes dfr_top, dfr_host and the bound checker are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

// ****************
// bench
// ****************
module tb_top;
    logic sys_clk, sys_rst, clk_en, deviation_err, limit_passed, ramp_done, warn_clear;
    logic [31:0] eeprom_bytes, obj_wdata, q;
    logic obj_wr, obj_rd, cw_write;
    logic [15:0] obj_index, cw_data;
    logic [1:0] ae;
    wire [31:0] obj_rdata_reg, hw_cfg_out_reg;
    wire [1:0] ramp_sel_reg;
    wire obj_ack_reg, obj_err_reg, drive_disable_reg, go_switch_on_disabled_reg;
    wire go_quick_stop_active_reg, go_operation_enabled_reg, energized_reg;
    wire status_warn_reg, qs_bit_out_reg;
    int fails = 0;
    int checks_done = 0;

    dfr_top dut (.*);
    dfr_host host (.*);

    always #25 sys_clk = ~sys_clk;

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s exp %h seen %h", n, e, s);
        end
    endtask

    task automatic final_report;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic do_rst;
        @(posedge sys_clk);
        #1 sys_rst = 1;
        repeat (4) @(posedge sys_clk);
        #1 sys_rst = 0;
    endtask

    task automatic pulse(ref logic s);
        @(posedge sys_clk);
        #1 s = 1;
        @(posedge sys_clk);
        #1 s = 0;
    endtask

    // data is only meaningful when the access was accepted
    task automatic rd(input logic [15:0] i, input logic [31:0] e, input logic [1:0] ea);
        host.acc(0, i, 0, q, ae);
        chk("ack_err", ae, ea);
        if (ea == 2'h2)
            chk("rdata", q, e);
    endtask

    task automatic wr(input logic [15:0] i, input logic [31:0] d, input logic [1:0] ea);
        host.acc(1, i, d, q, ae);
        chk("wr_ack_err", ae, ea);
    endtask

    task automatic t_regs;
        do_rst();
        rd(16'h3700, 32'hFFFFFFFF, 2'h2);
        rd(16'h3701, 32'hFFFFFFFF, 2'h2);
        rd(16'h4013, 32'h0, 2'h2);
        rd(16'h4012, 32'h0, 2'h2);
        eeprom_bytes = 32'h0000_8000;
        wr(16'h4012, 32'h1234, 2'h3);
        rd(16'h4012, 32'h0000_8000, 2'h2);
        wr(16'h4013, 32'hA5A5_0F0F, 2'h2);
        rd(16'h4013, 32'hA5A5_0F0F, 2'h2);
        chk("hw_cfg_out", hw_cfg_out_reg, 32'hA5A5_0F0F);
        rd(16'h5000, 32'h0, 2'h3);
        $display("t_regs done");
    endtask

    task automatic dev_case(input logic [15:0] c, input logic [1:0] r);
        do_rst();
        wr(16'h3700, {16'h0, c}, 2'h2);
        rd(16'h3700, {{16{c[15]}}, c}, 2'h2);
        pulse(deviation_err);
        chk("dev_ramp", ramp_sel_reg, r);
        chk("dev_sod", go_switch_on_disabled_reg, c == 16'h0);
        pulse(ramp_done);
        // free-wheel keeps its choice while the drive stays blocked
        chk("dev_idle", ramp_sel_reg, c == 16'h0);
        chk("disable", drive_disable_reg, c == 16'h0);
        chk("energized", energized_reg, c != 16'h0);
        $display("dev_case %h done", c);
    endtask

    task automatic lim_case(input logic [15:0] c, input logic [1:0] r, input logic sod,
        input logic qsa);
        do_rst();
        host.cw(16'h0004);
        wr(16'h3701, {16'h0, c}, 2'h2);
        pulse(limit_passed);
        chk("warn", status_warn_reg, 1);
        chk("lim_ramp", ramp_sel_reg, r);
        pulse(ramp_done);
        chk("to_disabled", go_switch_on_disabled_reg, sod);
        chk("to_qsa", go_quick_stop_active_reg, qsa);
        if (qsa)
            chk("energized", energized_reg, 1);
        chk("qs_bit", qs_bit_out_reg, 1);
        pulse(warn_clear);
        chk("warn_clr", status_warn_reg, 0);
        $display("lim_case %h done", c);
    endtask

    // a low enable must hold every register, events and accesses included
    task automatic t_freeze;
        do_rst();
        clk_en = 0;
        pulse(limit_passed);
        wr(16'h4013, 32'h0000_00FF, 2'h0);
        chk("frozen_warn", status_warn_reg, 0);
        chk("frozen_cfg", hw_cfg_out_reg, 0);
        @(posedge sys_clk);
        #1 clk_en = 1;
        $display("t_freeze done");
    endtask

    // both events in one cycle: only a usable deviation code takes precedence
    task automatic t_prio(input logic [15:0] dc, input logic [1:0] r);
        do_rst();
        wr(16'h3700, {16'h0, dc}, 2'h2);
        wr(16'h3701, 32'h0000_0001, 2'h2);
        @(posedge sys_clk);
        #1 {deviation_err, limit_passed} = 2'h3;
        @(posedge sys_clk);
        #1 {deviation_err, limit_passed} = 2'h0;
        chk("prio_ramp", ramp_sel_reg, r);
        chk("prio_warn", status_warn_reg, 1);
        $display("t_prio %h done", dc);
    endtask

    task automatic t_resume;
        lim_case(16'h0006, 2'h3, 0, 1);
        host.resume();
        @(posedge sys_clk);
        #1;
        chk("to_op", go_operation_enabled_reg, 1);
        $display("t_resume done");
    endtask

    initial
    begin
        {sys_clk, sys_rst, clk_en} = 3'h3;
        {deviation_err, limit_passed, ramp_done, warn_clear} = 4'h0;
        eeprom_bytes = 32'h0;
        t_regs();
        dev_case(16'h0001, 2'h2);
        dev_case(16'h0002, 2'h3);
        dev_case(16'h0003, 2'h0);
        dev_case(16'h7FFF, 2'h0);
        dev_case(16'hFFFF, 2'h0);
        dev_case(16'h0000, 2'h1);
        lim_case(16'hFFFF, 2'h0, 0, 0);
        lim_case(16'h0001, 2'h2, 1, 0);
        lim_case(16'h0002, 2'h3, 1, 0);
        lim_case(16'h0005, 2'h2, 0, 1);
        lim_case(16'h0003, 2'h0, 0, 0);
        t_freeze();
        t_prio(16'hFFFF, 2'h2);
        t_prio(16'h0002, 2'h3);
        t_resume();
        final_report();
    end

    // whole run is about 230 cycles; twenty thousand means a hang
    initial
    begin
        #1000000;
        fails++;
        final_report();
    end
endmodule // tb_top
`default_nettype wire
